// ===== hdl/aoc_map.svh
// constants of the offset compensation block: register indices,
// field positions, reset values and counts
// assumes inclusion by aoc_pkg only
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH

// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define AOC_ADDR_W 9
`define AOC_IDX_CTRL 7'h36
`define AOC_IDX_SET 7'h37
`define AOC_IDX_X 7'h38
`define AOC_IDX_Y 7'h39
`define AOC_IDX_Z 7'h3A
`define AOC_IDX_STAT 7'h40
`define AOC_IDX_MASK 7'h41

// ****************************************
// field positions
// ****************************************
`define AOC_CTRL_CLR 7
`define AOC_CTRL_TRG_HI 6
`define AOC_CTRL_TRG_LO 5
`define AOC_CTRL_RDY 4
`define AOC_SET_CUT 0
`define AOC_SET_TX_LO 1
`define AOC_SET_TY_LO 3
`define AOC_SET_TZ_LO 5
`define AOC_EV_DONE 0
`define AOC_EV_REFUSED 1
`define AOC_EV_RESTORED 2

// ****************************************
// reset values
// ****************************************
`define AOC_CTRL_RST 3'h0
`define AOC_SET_RST 7'h00
`define AOC_CORR_RST 8'h00
`define AOC_EV_RST 3'h0

// ****************************************
// arithmetic and counts
// ****************************************
`define AOC_ONE_G_2G 16'sh0400
`define AOC_OFF_SHIFT_2G 2'h3
`define AOC_HP_DIV_LO 24'sh0003E8
`define AOC_HP_DIV_HI 24'sh000064
`define AOC_FAST_LAST 4'hF
`define AOC_FAST_SHIFT 4
`define AOC_CORR_MAX 8'h7F
`define AOC_CORR_MIN 8'h80
`define AOC_RESP_OKAY 2'h0
`define AOC_RESP_SLVERR 2'h2

`endif

// ===== hdl/aoc_pkg.sv
// types and shared arithmetic of the offset compensation block
// assumes aoc_map.svh is on the include path
package aoc_pkg;
`include "aoc_map.svh"

	typedef logic [2:0][15:0] aoc_axes_t;
	typedef logic [2:0][7:0] aoc_corr_t;
	typedef struct packed {
		logic en;
		logic [6:0] idx;
		logic [7:0] data;
	} aoc_wr_t;
	typedef enum logic [1:0] {
		FC_IDLE = 2'b00,
		FC_ACCUM = 2'b01,
		FC_WRITE = 2'b11
	} aoc_fc_state_t;

	// one correction lsb is 1/128 g whatever the range
	function automatic logic signed [15:0] aoc_off_scale(
		input logic [7:0] off, input logic [1:0] rng);
		logic signed [15:0] v;
		v = $signed({{8{off[7]}}, off});
		return v <<< (`AOC_OFF_SHIFT_2G - rng);
	endfunction

	// range code 0..3 is 2/4/8/16 g, lsb of 1 g halves per step
	function automatic logic signed [15:0] aoc_target(
		input logic [1:0] code, input logic [1:0] rng);
		logic signed [15:0] one_g;
		one_g = `AOC_ONE_G_2G >>> rng;
		// 11b falls back to 0 g
		unique case (code)
			2'h1: return one_g;
			2'h2: return -one_g;
			default: return 16'sh0000;
		endcase
	endfunction

	function automatic logic aoc_map_hit(
		input logic [`AOC_ADDR_W-1:0] addr);
		logic [6:0] idx;
		idx = addr[8:2];
		return (addr[1:0] == 2'h0) &&
			((idx >= `AOC_IDX_CTRL && idx <= `AOC_IDX_Z) ||
			idx == `AOC_IDX_STAT || idx == `AOC_IDX_MASK);
	endfunction
endpackage

// ===== hdl/aoc_axil_slave.sv
// axi4-lite slave front end: holds address and data, hands one
// register write pulse to the owner, answers reads from rd_data
// assumes rd_data is a combinational function of s_axi_araddr
`timescale 1ns/100ps
module aoc_axil_slave import aoc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`AOC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`AOC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] rd_data,
	output aoc_wr_t wr
);
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [`AOC_ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wstrb_r, wstrb_nxt;
	logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0] bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	aoc_wr_t wr_nxt;
	logic fire;

	// ****************************************
	// write path
	// ****************************************
	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = s_axi_bvalid;
		bresp_nxt = s_axi_bresp;
		wr_nxt = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata[7:0];
			wstrb_nxt = s_axi_wstrb[0];
		end
		fire = aw_held_r && w_held_r && !s_axi_bvalid;
		if (fire) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			// only byte lane 0 carries register bits
			wr_nxt.en = aoc_map_hit(awaddr_r) && wstrb_r;
			wr_nxt.idx = awaddr_r[8:2];
			wr_nxt.data = wdata_r;
			bresp_nxt = aoc_map_hit(awaddr_r) ? `AOC_RESP_OKAY :
				`AOC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		awready_nxt = !aw_held_nxt && !bvalid_nxt;
		wready_nxt = !w_held_nxt && !bvalid_nxt;
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		rvalid_nxt = s_axi_rvalid;
		rdata_nxt = s_axi_rdata;
		rresp_nxt = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_data;
			rresp_nxt = aoc_map_hit(s_axi_araddr) ? `AOC_RESP_OKAY :
				`AOC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 8'h00;
			wstrb_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AOC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AOC_RESP_OKAY;
			wr <= '0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
			wr <= wr_nxt;
		end
	end
endmodule

// ===== hdl/aoc_axis.sv
// one axis: subtracts the correction from raw and filtered data and
// runs the slow high-pass tracker that nudges the correction
// assumes sample_valid, raw and filt come from logic on aclk
`timescale 1ns/100ps
module aoc_axis import aoc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sample_valid,
	input wire logic [15:0] raw,
	input wire logic [15:0] filt,
	input wire logic [7:0] corr,
	input wire logic [1:0] rng,
	input wire logic [1:0] target,
	input wire logic hp_en,
	input wire logic cut_off,
	output logic [15:0] raw_corr,
	output logic [15:0] filt_corr,
	output logic step_up,
	output logic step_dn
);
	logic signed [15:0] off_lsb;
	logic signed [23:0] frac_r, frac_nxt, thr, err;
	logic [15:0] raw_nxt, filt_nxt;

	always_comb begin
		off_lsb = aoc_off_scale(corr, rng);
		raw_nxt = raw_corr;
		filt_nxt = filt_corr;
		if (sample_valid) begin
			raw_nxt = 16'($signed(raw) - off_lsb);
			filt_nxt = 16'($signed(filt) - off_lsb);
		end
		thr = (cut_off ? `AOC_HP_DIV_HI : `AOC_HP_DIV_LO) <<<
			(`AOC_OFF_SHIFT_2G - rng);
		err = 24'($signed(filt) - off_lsb - aoc_target(target, rng));
		frac_nxt = frac_r;
		step_up = 1'b0;
		step_dn = 1'b0;
		if (!hp_en) begin
			frac_nxt = 24'sh000000;
		end else if (sample_valid) begin
			frac_nxt = frac_r + err;
			if (frac_nxt >= thr) begin
				step_up = 1'b1;
				frac_nxt = frac_nxt - thr;
			end else if (frac_nxt <= -thr) begin
				step_dn = 1'b1;
				frac_nxt = frac_nxt + thr;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frac_r <= 24'sh000000;
			raw_corr <= 16'h0000;
			filt_corr <= 16'h0000;
		end else begin
			frac_r <= frac_nxt;
			raw_corr <= raw_nxt;
			filt_corr <= filt_nxt;
		end
	end
endmodule

// ===== hdl/aoc_top.sv
// offset compensation for a three-axis accelerometer behind an
// axi4-lite register port
// assumes data, range, nvm image and soft reset come from the sensor
// core on aclk, so none of them is synchronised here
//
// Function
// - Writing one to the clear-all bit zeroes all three corrections, zero leaves them.
// - Trigger code 01b starts fast compensation on x, 10b on y, 11b on z, 00b nothing.
// - The ready flag reads zero while fast compensation runs and one when it may restart.
// - One enable bit per axis switches slow compensation of that axis on or off.
// - Each axis target field picks 0 g for 00b and 11b, +1 g for 01b, -1 g for 10b.
// - The cut-off bit sets the slow corner to bandwidth/1000 when zero, /100 when one.
// - Each axis correction is subtracted from its filtered and unfiltered data.
// - Corrections are signed bytes of 1/128 g each, whatever the selected range.
// - Every correction reloads from the non-volatile image at power-on and soft reset.
// - A triggered fast compensation computes and writes that axis correction itself.
// - Software may write corrections directly and the written value is then used.
// - The corrections are offered as the image to store in non-volatile memory.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module aoc_top import aoc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`AOC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`AOC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic soft_reset,
	input wire aoc_corr_t nvm_image,
	output aoc_corr_t nvm_store_image,
	input wire logic sample_valid,
	input wire logic [1:0] acc_range,
	input wire aoc_axes_t acc_raw,
	input wire aoc_axes_t acc_filt,
	output logic corr_valid,
	output aoc_axes_t acc_raw_corr,
	output aoc_axes_t acc_filt_corr,
	output logic irq
);
	aoc_wr_t wr;
	logic [31:0] rd_data;
	logic [2:0] step_up, step_dn;

	logic [2:0] slow_comp_enable_r, slow_comp_enable_nxt;
	logic [6:0] settings_r, settings_nxt;
	aoc_corr_t corr_r, corr_nxt;
	aoc_fc_state_t fc_state_r, fc_state_nxt;
	logic [1:0] fc_axis_r, fc_axis_nxt;
	logic [3:0] fc_cnt_r, fc_cnt_nxt;
	logic signed [19:0] fc_sum_r, fc_sum_nxt;
	logic restore_r, restore_nxt;
	logic [2:0] status_r, status_nxt, mask_r, mask_nxt, ev;
	logic irq_nxt, corr_valid_nxt;

	logic ctrl_wr, fc_ready;
	logic [1:0] trig;
	logic signed [15:0] fc_avg;
	logic signed [16:0] fc_diff;
	logic [7:0] fc_result;

	// saturate a signed value into one correction byte
	function automatic logic [7:0] sat8(input logic signed [16:0] v);
		if (v > 17'sd127) begin
			return `AOC_CORR_MAX;
		end else if (v < -17'sd128) begin
			return `AOC_CORR_MIN;
		end
		return v[7:0];
	endfunction

	function automatic logic [1:0] axis_target(input logic [6:0] s,
		input int i);
		unique case (i)
			0: return s[`AOC_SET_TX_LO +: 2];
			1: return s[`AOC_SET_TY_LO +: 2];
			default: return s[`AOC_SET_TZ_LO +: 2];
		endcase
	endfunction

	// ****************************************
	// register port
	// ****************************************
	aoc_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rd_data(rd_data),
		.wr(wr)
	);

	// ****************************************
	// per-axis datapath
	// ****************************************
	for (genvar g = 0; g < 3; g++) begin : g_axis
		aoc_axis u_axis (
			.aclk(aclk),
			.aresetn(aresetn),
			.sample_valid(sample_valid),
			.raw(acc_raw[g]),
			.filt(acc_filt[g]),
			.corr(corr_r[g]),
			.rng(acc_range),
			.target(axis_target(settings_r, g)),
			.hp_en(slow_comp_enable_r[g]),
			.cut_off(settings_r[`AOC_SET_CUT]),
			.raw_corr(acc_raw_corr[g]),
			.filt_corr(acc_filt_corr[g]),
			.step_up(step_up[g]),
			.step_dn(step_dn[g])
		);
	end

	// ****************************************
	// read decode
	// ****************************************
	// ready is the idle state
	assign fc_ready = (fc_state_r == FC_IDLE);

	always_comb begin
		rd_data = 32'h00000000;
		unique case (s_axi_araddr[8:2])
			// write-only control bits read back as zero
			`AOC_IDX_CTRL: rd_data[7:0] = {3'h0, fc_ready, 1'b0,
				slow_comp_enable_r};
			`AOC_IDX_SET: rd_data[7:0] = {1'b0, settings_r};
			`AOC_IDX_X: rd_data[7:0] = corr_r[0];
			`AOC_IDX_Y: rd_data[7:0] = corr_r[1];
			`AOC_IDX_Z: rd_data[7:0] = corr_r[2];
			`AOC_IDX_STAT: rd_data[2:0] = status_r;
			`AOC_IDX_MASK: rd_data[2:0] = mask_r;
			default: rd_data = 32'h00000000;
		endcase
	end

	// ****************************************
	// fast compensation
	// ****************************************
	always_comb begin
		ctrl_wr = wr.en && (wr.idx == `AOC_IDX_CTRL);
		trig = wr.data[`AOC_CTRL_TRG_HI:`AOC_CTRL_TRG_LO];
		fc_state_nxt = fc_state_r;
		fc_axis_nxt = fc_axis_r;
		fc_cnt_nxt = fc_cnt_r;
		fc_sum_nxt = fc_sum_r;
		ev = `AOC_EV_RST;
		// average of uncorrected data minus target
		fc_avg = 16'(fc_sum_r >>> `AOC_FAST_SHIFT);
		fc_diff = 17'(fc_avg) - 17'(aoc_target(
			axis_target(settings_r, int'(fc_axis_r)), acc_range));
		fc_result = sat8(fc_diff >>> (`AOC_OFF_SHIFT_2G - acc_range));
		// a trigger while busy is dropped and flagged
		if (ctrl_wr && trig != 2'h0 && !fc_ready) begin
			ev[`AOC_EV_REFUSED] = 1'b1;
		end
		unique case (fc_state_r)
			FC_IDLE: begin
				// code minus one picks the axis
				if (ctrl_wr && trig != 2'h0) begin
					fc_axis_nxt = trig - 2'h1;
					fc_cnt_nxt = 4'h0;
					fc_sum_nxt = 20'sh00000;
					fc_state_nxt = FC_ACCUM;
				end
			end
			FC_ACCUM: begin
				if (sample_valid) begin
					fc_sum_nxt = fc_sum_r +
						20'($signed(acc_filt[fc_axis_r]));
					fc_cnt_nxt = fc_cnt_r + 4'h1;
					if (fc_cnt_r == `AOC_FAST_LAST) begin
						fc_state_nxt = FC_WRITE;
					end
				end
			end
			FC_WRITE: begin
				// back to ready with the write
				fc_state_nxt = FC_IDLE;
				ev[`AOC_EV_DONE] = 1'b1;
			end
		endcase
		ev[`AOC_EV_RESTORED] = restore_r;
		// soft reset aborts a running compensation
		if (soft_reset) begin
			fc_state_nxt = FC_IDLE;
		end
	end

	// ****************************************
	// control and correction registers
	// ****************************************
	always_comb begin
		slow_comp_enable_nxt = slow_comp_enable_r;
		settings_nxt = settings_r;
		mask_nxt = mask_r;
		corr_nxt = corr_r;
		restore_nxt = soft_reset;
		if (ctrl_wr) begin
			slow_comp_enable_nxt = wr.data[2:0];
		end
		if (wr.en && wr.idx == `AOC_IDX_SET) begin
			settings_nxt = wr.data[6:0];
		end
		if (wr.en && wr.idx == `AOC_IDX_MASK) begin
			mask_nxt = wr.data[2:0];
		end
		for (int i = 0; i < 3; i++) begin
			if (restore_r) begin
				corr_nxt[i] = nvm_image[i];
			end else if (ctrl_wr && wr.data[`AOC_CTRL_CLR]) begin
				corr_nxt[i] = `AOC_CORR_RST;
			end else if (wr.en && wr.idx == 7'(`AOC_IDX_X + i)) begin
				corr_nxt[i] = wr.data;
			end else if (fc_state_r == FC_WRITE &&
				int'(fc_axis_r) == i) begin
				corr_nxt[i] = fc_result;
			end else if (step_up[i] && corr_r[i] != `AOC_CORR_MAX) begin
				corr_nxt[i] = corr_r[i] + 8'h01;
			end else if (step_dn[i] && corr_r[i] != `AOC_CORR_MIN) begin
				corr_nxt[i] = corr_r[i] - 8'h01;
			end
		end
		if (soft_reset) begin
			slow_comp_enable_nxt = `AOC_CTRL_RST;
			settings_nxt = `AOC_SET_RST;
		end
		// set wins over a one written in the same cycle
		status_nxt = status_r;
		if (wr.en && wr.idx == `AOC_IDX_STAT) begin
			status_nxt = status_r & ~wr.data[2:0];
		end
		status_nxt = status_nxt | ev;
		irq_nxt = |(status_nxt & mask_nxt);
		corr_valid_nxt = sample_valid;
	end

	assign nvm_store_image = corr_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_comp_enable_r <= `AOC_CTRL_RST;
			settings_r <= `AOC_SET_RST;
			corr_r <= '0;
			// power-on restore happens in the first cycle after reset
			restore_r <= 1'b1;
			fc_state_r <= FC_IDLE;
			fc_axis_r <= 2'h0;
			fc_cnt_r <= 4'h0;
			fc_sum_r <= 20'sh00000;
			status_r <= `AOC_EV_RST;
			mask_r <= `AOC_EV_RST;
			irq <= 1'b0;
			corr_valid <= 1'b0;
		end else begin
			slow_comp_enable_r <= slow_comp_enable_nxt;
			settings_r <= settings_nxt;
			corr_r <= corr_nxt;
			restore_r <= restore_nxt;
			fc_state_r <= fc_state_nxt;
			fc_axis_r <= fc_axis_nxt;
			fc_cnt_r <= fc_cnt_nxt;
			fc_sum_r <= fc_sum_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq <= irq_nxt;
			corr_valid <= corr_valid_nxt;
		end
	end
endmodule

// ===== test/aoc_top_props.sv
// concurrent checks on the ports of the offset compensation top
// assumes it is bound into aoc_top, one clock, reset active low
`timescale 1ns/100ps
module aoc_top_props import aoc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sample_valid,
	input wire aoc_axes_t acc_raw,
	input wire aoc_axes_t acc_filt,
	input wire logic corr_valid,
	input wire aoc_axes_t acc_raw_corr,
	input wire aoc_axes_t acc_filt_corr,
	input wire logic irq
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_valid;
		sample_valid |=> corr_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("no corrected sample");

	// same correction on both paths, so the gap between them survives
	property p_diff_x;
		sample_valid |=> acc_raw_corr[0] - acc_filt_corr[0] ==
			$past(acc_raw[0]) - $past(acc_filt[0]);
	endproperty
	a_diff_x: assert property (p_diff_x) else $error("x paths differ");

	property p_diff_z;
		sample_valid |=> acc_raw_corr[2] - acc_filt_corr[2] ==
			$past(acc_raw[2]) - $past(acc_filt[2]);
	endproperty
	a_diff_z: assert property (p_diff_z) else $error("z paths differ");

	property p_rst;
		$rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live after reset");

	property p_b_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("late write response");

	property p_b_hs;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_hs: assert property (p_b_hs) else $error("response repeated");

	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write not held off");

	property p_ar_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_ar_lat: assert property (p_ar_lat) else $error("late read data");

	property p_r_hs;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready;
	endproperty
	a_r_hs: assert property (p_r_hs) else $error("read not closed");

	property p_rdata;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("upper read bits set");
endmodule

bind aoc_top aoc_top_props u_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .sample_valid, .acc_raw, .acc_filt,
	.corr_valid, .acc_raw_corr, .acc_filt_corr, .irq);

// ===== test/test_accel_offset_compensation.sv
// self-checking bench of the offset compensation block
// assumes aoc_pkg, aoc_top and the checker are compiled first
`timescale 1ns/100ps
module test_accel_offset_compensation import aoc_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, soft_reset, sample_valid;
	logic corr_valid, irq;
	logic [8:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, acc_range, rsp;
	aoc_corr_t nvm_image, nvm_store_image;
	aoc_axes_t acc_raw, acc_filt, acc_raw_corr, acc_filt_corr;
	int num_errors = 0;
	int check_count = 0;
	int cyc_cnt = 0;

	aoc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .soft_reset,
		.nvm_image, .nvm_store_image, .sample_valid, .acc_range, .acc_raw,
		.acc_filt, .corr_valid, .acc_raw_corr, .acc_filt_corr, .irq);

	always #10 aclk = ~aclk;

	// run takes under a thousand cycles, so this only catches a hang
	always @(posedge aclk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			num_errors++;
			finish_test();
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] idx);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdc(input logic [6:0] idx, input logic [7:0] e);
		rd(idx);
		chk(rdat, {24'h000000, e});
	endtask

	task automatic smp(input int n, input logic [15:0] v);
		repeat (n) begin
			@(posedge aclk);
			acc_filt <= {3{v}};
			sample_valid <= 1'b1;
			@(posedge aclk);
			sample_valid <= 1'b0;
		end
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{aresetn, soft_reset, sample_valid, acc_range} <= 5'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
		{s_axi_arvalid, s_axi_rready} <= 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 50'h0;
		s_axi_wstrb <= 4'hF;
		nvm_image <= 24'h112233;
		acc_raw <= 48'h0;
		acc_filt <= 48'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(2);
		rdc(7'h38, 8'h33);
		rdc(7'h39, 8'h22);
		rdc(7'h3A, 8'h11);
		rdc(7'h36, 8'h10);
		rdc(7'h37, 8'h00);
		rdc(7'h40, 8'h04);
		rd(7'h3B);
		chk({30'h0, rsp}, 32'h2);
		wr(7'h3B, 8'h5A);
		chk({30'h0, rsp}, 32'h2);
		chk({8'h00, nvm_store_image}, 32'h00112233);
		$display("test 1 done");
		wr(7'h38, 8'h05);
		acc_raw <= {3{16'h0100}};
		smp(1, 16'h0200);
		cyc(2);
		chk({16'h0, acc_raw_corr[0]}, 32'h00D8);
		chk({16'h0, acc_filt_corr[0]}, 32'h01D8);
		acc_range <= 2'h3;
		smp(1, 16'h0200);
		cyc(2);
		chk({16'h0, acc_raw_corr[0]}, 32'h00FB);
		chk({16'h0, acc_raw_corr[1]}, 32'h00DE);
		acc_range <= 2'h0;
		$display("test 2 done");
		wr(7'h36, 8'h00);
		rdc(7'h38, 8'h05);
		rdc(7'h36, 8'h10);
		wr(7'h36, 8'h80);
		for (int i = 0; i < 3; i++) rdc(7'h38 + 7'(i), 8'h00);
		$display("test 3 done");
		// all targets at +1 g, data 1 g plus 8 correction steps
		wr(7'h37, 8'h2A);
		for (int c = 1; c < 4; c++) begin
			wr(7'h36, {1'b0, 2'(c), 5'h00});
			rdc(7'h36, 8'h00);
			if (c == 1) wr(7'h36, 8'h40);
			smp(16, 16'h0440);
			cyc(4);
			rdc(7'h36, 8'h10);
			for (int i = 0; i < 3; i++)
				rdc(7'h38 + 7'(i), (i < c) ? 8'h08 : 8'h00);
		end
		// y at -1 g, z at 11b meaning 0 g, both 4 steps above target
		wr(7'h37, 8'h70);
		wr(7'h36, 8'h40);
		smp(16, 16'hFC20);
		cyc(4);
		rdc(7'h39, 8'h04);
		wr(7'h36, 8'h60);
		smp(16, 16'h0020);
		cyc(4);
		rdc(7'h3A, 8'h04);
		rdc(7'h40, 8'h07);
		wr(7'h41, 8'h02);
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		wr(7'h40, 8'h02);
		cyc(3);
		chk({31'h0, irq}, 32'h0);
		rdc(7'h40, 8'h05);
		$display("test 4 done");
		// 13 samples of 64 cross the 800 threshold, 12 do not
		wr(7'h36, 8'h80);
		wr(7'h37, 8'h01);
		wr(7'h36, 8'h01);
		smp(12, 16'h0040);
		cyc(3);
		rdc(7'h38, 8'h00);
		smp(1, 16'h0040);
		cyc(3);
		rdc(7'h38, 8'h01);
		rdc(7'h39, 8'h00);
		wr(7'h36, 8'h80);
		wr(7'h37, 8'h00);
		wr(7'h36, 8'h01);
		smp(13, 16'h0040);
		cyc(3);
		rdc(7'h38, 8'h00);
		$display("test 5 done");
		wr(7'h38, 8'h55);
		@(posedge aclk);
		soft_reset <= 1'b1;
		@(posedge aclk);
		soft_reset <= 1'b0;
		cyc(4);
		rdc(7'h38, 8'h33);
		rdc(7'h36, 8'h10);
		$display("test 6 done");
		finish_test();
	end
endmodule
